// ---- adc_control_and_result_dma_test.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_and_result_dma_test;
  import adc_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [31:0] wdata_i = 32'h0;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic [15:0] raw_result_i = 16'h0123;
  logic [31:0] rdata_o;
  analog_cfg_t analog_cfg_o;
  logic conv_done_o;
  ram_write_t ram_write_o;
  logic irq_o;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_wr = 0;
  int m_start, m_len, m_cnt, k;
  int off = 16;
  int gain = 24576;
  bit big = 0;
  logic [31:0] seed = 32'h1DF243BB;
  logic [15:0] e_mem [0:8191];
  logic [15:0] ofs [12] = '{16'hA810, 16'hA850, 16'hD004, 16'hD008, 16'hD00C, 16'hD010,
    16'hD014, 16'hD018, 16'hD01C, 16'hD020, 16'hD024, 16'hD028};
  logic [31:0] rv [12] = '{32'h0, 32'h0, 32'h1800, 32'h0, 32'h8000, 32'h0, 32'h0,
    32'h2000_0000, 32'h0, 32'h2000_0000, 32'h0, 32'h0};

  adc_ctrl #(.STARTUP_CYCLES(10)) u_adc_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
    .rdata_o(rdata_o), .raw_result_i(raw_result_i), .analog_cfg_o(analog_cfg_o),
    .conv_done_o(conv_done_o), .ram_write_o(ram_write_o), .irq_o(irq_o));
  adc_result_ram u_adc_result_ram (.clk_i(clk_i), .wr_i(ram_write_o));

  always #10 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // offset first, then 1.15 gain, then clamp to the signed range
  function automatic logic [15:0] fix(input logic [15:0] r);
    int v;
    v = (int'($signed(r)) + off) * gain;
    v = v >>> 15;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask

  task automatic wait_done();
    k = 0;
    while (conv_done_o !== 1'b1 && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
  endtask

  // whole clocks between two done pulses
  task automatic meas(input int e);
    wait_done();
    @(negedge clk_i);
    wait_done();
    chk(k + 1, e);
  endtask

  task automatic wait_wr(input int n);
    k = 0;
    while (n_wr < n && k < 5000) begin
      @(negedge clk_i);
      k++;
    end
    chk(n_wr, n);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // result monitor: model address, data and wrap
  always @(posedge clk_i) begin
    if (ram_write_o.valid === 1'b1) begin
      chk(32'(ram_write_o.addr), 32'(m_start + m_cnt));
      chk(32'(ram_write_o.data), 32'(fix(raw_result_i)));
      e_mem[m_start + m_cnt] = fix(raw_result_i);
      n_wr++;
      m_cnt++;
      if (m_cnt == m_len) m_cnt = 0;
      seed = lfsr(seed);
      raw_result_i <= big ? {8'h70, seed[7:0]} : {{5{seed[10]}}, seed[10:0]};
    end
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 12; i++) rd(ofs[i], rv[i]);
    $display("test reset_values done");
    // high range input kept off ground and half-regulator
    wr(16'hD004, 32'h154A);
    rd(16'hD004, 32'h1548);
    chk(32'(analog_cfg_o), 32'({14'h1548 >> 2, 1'b0}));
    $display("test config done");
    m_start = 256;
    m_len = 4;
    m_cnt = 0;
    wr(16'hD010, 32'h10);
    wr(16'hD018, 32'h100);
    wr(16'hD01C, 32'h4);
    wr(16'hD008, 32'h10);
    wr(16'hD00C, 32'h6000);
    wr(16'hA850, 32'h1E);
    wr(16'hD004, 32'h1549);
    wait_done();
    chk(k >= 70 && k <= 82, 1);
    rd(16'hD014, 32'h2);
    wr(16'hD010, 32'h10);
    rd(16'hD014, 32'h0);
    wr(16'hD010, 32'h1);
    rd(16'hD010, 32'h0);
    rd(16'hD014, 32'h1);
    rd(16'hD020, 32'h2000_0200);
    rd(16'hD024, 32'h0);
    wait_wr(4);
    rd(16'hA810, 32'h16);
    chk(irq_o, 1'b1);
    wait_done();
    @(negedge clk_i);
    wait_done();
    chk(n_wr, 4);
    rd(16'hD014, 32'h2);
    rd(16'hD024, 32'h4);
    wr(16'hA810, 32'h6);
    rd(16'hA810, 32'h10);
    wr(16'hA850, 32'h8);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1'b0);
    $display("test linear_dma done");
    big = 1;
    wr(16'hD010, 32'h10);
    wr(16'hD01C, 32'h3);
    wr(16'hD00C, 32'hFFFF);
    gain = 65535;
    m_len = 3;
    m_cnt = 0;
    wr(16'hD010, 32'h3);
    wr(16'hA810, 32'h1E);
    rd(16'hD010, 32'h2);
    wait_wr(n_wr + 5);
    rd(16'hA810, 32'hE);
    chk(irq_o, 1'b1);
    meas(32);
    wr(16'hD004, 32'h154D);
    wait_done();
    meas(192);
    for (int i = 0; i < 3; i++) chk(u_adc_result_ram.mem[256 + i], e_mem[256 + i]);
    $display("test wrap_saturate done");
    stop_test();
  end
endmodule

// ---- adc_ctrl.sv ----
// converter control, correction and result dma
// Functional notes
// RULE1: sample code 0..7 gives 32..4096 converter clocks per conversion
// RULE2: positive range bit 1 selects high range with buffer on
// RULE3: negative range bit 1 selects high range with buffer on
// RULE4: positive selector passes its 4-bit code to the analog mux
// RULE5: negative selector uses the same code map as positive
// RULE6: software avoids ground or half-regulator on a high-range input
// RULE7: clock bit 0 runs at 6 MHz, 1 at 1 MHz
// RULE8: converter-on bit starts continuous conversions; software alone changes it
// RULE9: first conversion takes double clocks plus 21 us startup
// RULE10: control write while running doubles the next conversion; here only a write that changes the control register doubles it
// RULE11: signed offset added to raw result before gain
// RULE12: gain is unsigned 1.15 fixed point, reset means unity
// RULE13: output equals offset-corrected result times gain
// RULE14: dma reset bit resets the dma and self-clears
// RULE15: wrap bit 0 stops at full, 1 wraps to start
// RULE16: load bit 1 starts dma, 0 ignored; clears on start or reset
// RULE17: overrun status sets on result while dma idle; dma reset clears
// RULE18: active bit reads 1 while the dma runs
// RULE19: 13-bit start address where the dma begins writing
// RULE20: length counts 16-bit results, buffer spans twice that in bytes
// RULE21: next address in bits 13:1 gives the next halfword written
// RULE22: written count reports results stored so far
// RULE23: full flag on last location, half flag on last of first half
// RULE24: saturation flag when gain product leaves signed 16-bit range
// RULE25: writing 1 clears an event flag, 0 leaves it
// RULE26: a flag requests the interrupt only when its enable is set
// RULE27: saturated results are clamped to the nearest signed limit
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int CLK_MHZ = 50,
  parameter int STARTUP_CYCLES = (`STARTUP_NS * CLK_MHZ + 999) / 1000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [31:0] rdata_o,
  input wire logic [15:0] raw_result_i,
  output analog_cfg_t analog_cfg_o,
  output logic conv_done_o,
  output ram_write_t ram_write_o,
  output logic irq_o
);
  // conversion timing
  localparam int CNT_W = 20;
  logic [15:0] ctrl_reg;
  logic [15:0] offset_reg;
  logic [15:0] gain_reg;
  logic wrap_reg;
  logic load_reg;
  logic active_reg;
  logic ovr_reg;
  logic [12:0] start_reg;
  logic [12:0] length_reg;
  logic [12:0] next_reg;
  logic [12:0] count_reg;
  logic [4:0] flags_reg;
  logic [4:0] enables_reg;
  conv_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic double_reg;
  logic [2:0] div_reg;
  logic tick;
  logic [CNT_W-1:0] conv_clocks;
  logic ctrl_wr;
  logic ctrl_change;
  logic done_pulse;
  logic [15:0] raw_sync1_reg;
  logic [15:0] raw_sync2_reg;
  logic signed [16:0] sum;
  logic signed [33:0] product;
  logic signed [18:0] scaled;
  logic gain_saturation_flag;
  logic [15:0] corrected;
  logic dma_rst;
  logic last_hit;
  logic half_hit;

  assign ctrl_wr = write_i && addr_i == `OFS_CONV_CTRL;
  assign ctrl_change = ctrl_wr && (wdata_i[15:0] & `CTRL_WMASK) != ctrl_reg;
  assign dma_rst = write_i && addr_i == `OFS_DMA_CTRL && wdata_i[`BIT_DMA_RST];
  // converter clock enable derived from the system clock
  assign tick = div_reg == 3'h0;
  assign conv_clocks = CNT_W'(`BASE_CLOCKS) << ctrl_reg[`SMP_LSB +: 3]; // RULE1

  // software writes only; hardware never touches the on bit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= `RST_CONV_CTRL;
    end else if (ctrl_wr) begin
      ctrl_reg <= wdata_i[15:0] & `CTRL_WMASK; // RULE8
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_reg <= 3'h0;
    end else if (tick) begin
      div_reg <= ctrl_reg[`BIT_CLK] ? 3'(`SLOW_DIV - 1) : 3'(`FAST_DIV - 1); // RULE7
    end else begin
      div_reg <= div_reg - 3'h1;
    end
  end

  // sequencer: startup delay, then back-to-back conversions
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_OFF;
      cnt_reg <= '0;
      double_reg <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      case (state_reg)
        ST_OFF: begin
          if (ctrl_wr && wdata_i[`BIT_ON]) begin
            state_reg <= ST_START; // RULE8
            cnt_reg <= CNT_W'(STARTUP_CYCLES); // RULE9
            double_reg <= 1'b1; // RULE9
          end
        end
        ST_START: begin
          if (ctrl_wr && !wdata_i[`BIT_ON]) begin
            state_reg <= ST_OFF;
          end else if (cnt_reg <= CNT_W'(1)) begin
            state_reg <= ST_RUN;
            cnt_reg <= conv_clocks << 1; // RULE9
            double_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        ST_RUN: begin
          if (ctrl_wr && !wdata_i[`BIT_ON]) begin
            state_reg <= ST_OFF;
          end else if (ctrl_change) begin
            cnt_reg <= conv_clocks << 1; // RULE10
          end else if (tick) begin
            if (cnt_reg <= CNT_W'(1)) begin
              cnt_reg <= conv_clocks;
              done_pulse <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg - CNT_W'(1);
            end
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  // raw result comes from the analog side, so it is resynchronised
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raw_sync1_reg <= '0;
      raw_sync2_reg <= '0;
    end else begin
      raw_sync1_reg <= raw_result_i;
      raw_sync2_reg <= raw_sync1_reg;
    end
  end

  always_comb begin
    sum = $signed({raw_sync2_reg[15], raw_sync2_reg}) + $signed({offset_reg[15], offset_reg}); // RULE11
    product = sum * $signed({1'b0, gain_reg}); // RULE12 RULE13
    scaled = product[33:15];
    gain_saturation_flag = scaled > 19'sd32767 || scaled < -19'sd32768; // RULE24
    if (!gain_saturation_flag) begin
      corrected = scaled[15:0];
    end else if (scaled[18]) begin
      corrected = `SAT_MIN; // RULE27
    end else begin
      corrected = `SAT_MAX; // RULE27
    end
  end

  // software-owned registers; reserved bits simply dropped
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      offset_reg <= '0;
      gain_reg <= `RST_GAIN_CORR; // RULE12
      start_reg <= 13'(`RST_START_ADDR);
      length_reg <= '0;
      enables_reg <= '0;
      wrap_reg <= 1'b0;
    end else if (write_i) begin
      case (addr_i)
        `OFS_OFFSET_CORR: offset_reg <= wdata_i[15:0];
        `OFS_GAIN_CORR: gain_reg <= wdata_i[15:0];
        `OFS_START_ADDR: start_reg <= wdata_i[12:0]; // RULE19
        `OFS_LENGTH: length_reg <= wdata_i[12:0]; // RULE20
        `OFS_EVENT_ENABLES: enables_reg <= wdata_i[4:0] & `FLG_MASK;
        `OFS_DMA_CTRL: wrap_reg <= wdata_i[`BIT_WRAP];
        default: begin
        end
      endcase
    end
  end

  assign last_hit = count_reg + 13'h1 == length_reg;
  assign half_hit = count_reg + 13'h1 == (length_reg >> 1) && length_reg > 13'h1;

  // dma engine: one halfword per result, next address in halfword units
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_reg <= 1'b0;
      active_reg <= 1'b0;
      ovr_reg <= 1'b0;
      next_reg <= '0;
      count_reg <= '0;
      ram_write_o <= '0;
    end else begin
      ram_write_o.valid <= 1'b0;
      if (dma_rst) begin
        load_reg <= 1'b0; // RULE14 RULE16
        active_reg <= 1'b0; // RULE14
        ovr_reg <= 1'b0; // RULE17
        count_reg <= '0;
        next_reg <= start_reg;
      end else if (load_reg) begin
        load_reg <= 1'b0; // RULE16
        active_reg <= length_reg != 13'h0;
        next_reg <= start_reg;
        count_reg <= '0;
      end else if (write_i && addr_i == `OFS_DMA_CTRL && wdata_i[`BIT_LOAD]) begin
        load_reg <= 1'b1; // RULE16
      end
      if (done_pulse && !dma_rst) begin
        if (!active_reg) begin
          ovr_reg <= 1'b1; // RULE17
        end else begin
          ram_write_o.valid <= 1'b1;
          ram_write_o.addr <= next_reg;
          ram_write_o.data <= corrected;
          if (last_hit && wrap_reg) begin
            next_reg <= start_reg; // RULE15
            count_reg <= '0;
          end else begin
            next_reg <= next_reg + 13'h1;
            count_reg <= count_reg + 13'h1; // RULE22
            active_reg <= !last_hit; // RULE15
          end
        end
      end
    end
  end

  // event flags: set beats a simultaneous write-1 clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_reg <= '0;
    end else begin
      logic [4:0] set_v;
      set_v = '0;
      set_v[`FLG_HALF] = done_pulse && active_reg && half_hit; // RULE23
      set_v[`FLG_FULL] = done_pulse && active_reg && last_hit; // RULE23
      set_v[`FLG_SAT] = done_pulse && gain_saturation_flag; // RULE24
      set_v[`FLG_OVR] = done_pulse && !active_reg; // RULE17
      if (write_i && addr_i == `OFS_EVENT_FLAGS) begin
        flags_reg <= (flags_reg & ~(wdata_i[4:0] & `FLG_MASK)) | set_v; // RULE25
      end else begin
        flags_reg <= flags_reg | set_v;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_reg & enables_reg); // RULE26
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      analog_cfg_o <= '0;
      conv_done_o <= 1'b0;
    end else begin
      analog_cfg_o.sample_time_sel <= ctrl_reg[15:13];
      analog_cfg_o.pos_high_range_sel <= ctrl_reg[12]; // RULE2
      analog_cfg_o.neg_high_range_sel <= ctrl_reg[11]; // RULE3
      analog_cfg_o.pos_input_sel <= ctrl_reg[10:7]; // RULE4
      analog_cfg_o.neg_input_sel <= ctrl_reg[6:3]; // RULE5
      analog_cfg_o.clk_sel <= ctrl_reg[`BIT_CLK];
      analog_cfg_o.converter_on <= ctrl_reg[`BIT_ON];
      conv_done_o <= done_pulse;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (!read_i) begin
      rdata_o <= '0;
    end else begin
      case (addr_i)
        `OFS_EVENT_FLAGS: rdata_o <= {27'h0, flags_reg};
        `OFS_EVENT_ENABLES: rdata_o <= {27'h0, enables_reg};
        `OFS_CONV_CTRL: rdata_o <= {16'h0, ctrl_reg};
        `OFS_OFFSET_CORR: rdata_o <= {16'h0, offset_reg};
        `OFS_GAIN_CORR: rdata_o <= {16'h0, gain_reg};
        `OFS_DMA_CTRL: rdata_o <= {30'h0, wrap_reg, load_reg};
        `OFS_DMA_STATUS: rdata_o <= {30'h0, ovr_reg, active_reg}; // RULE17 RULE18
        `OFS_START_ADDR: rdata_o <= {19'h0, start_reg} | `RST_START_ADDR;
        `OFS_LENGTH: rdata_o <= {19'h0, length_reg};
        `OFS_NEXT_ADDR: rdata_o <= {18'h0, next_reg, 1'b0} | `RST_START_ADDR; // RULE21
        `OFS_WRITTEN_CNT: rdata_o <= {19'h0, count_reg}; // RULE22
        default: rdata_o <= '0;
      endcase
    end
  end

  AST_SAT_CLAMP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    gain_saturation_flag && !scaled[18] |-> corrected == `SAT_MAX) else $error("clamp high wrong"); // RULE27
  AST_START_DELAY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_reg == ST_OFF && ctrl_wr && wdata_i[`BIT_ON] |=> state_reg == ST_START) else $error("no start"); // RULE9
  AST_ON_STABLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_wr |=> $stable(ctrl_reg[`BIT_ON])) else $error("on bit moved"); // RULE8
  AST_LOAD_CLEARS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    load_reg |=> !load_reg) else $error("load stuck"); // RULE16
  AST_RST_CLEARS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    dma_rst |=> !ovr_reg && !active_reg && !load_reg) else $error("dma reset failed"); // RULE14
  AST_OVR_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_pulse && !active_reg && !dma_rst |=> ovr_reg && flags_reg[`FLG_OVR]) else $error("overrun"); // RULE17
  AST_LINEAR_STOP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_pulse && active_reg && last_hit && !wrap_reg && !dma_rst |=> !active_reg) else $error("stop"); // RULE15
  AST_IRQ: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (flags_reg & enables_reg) == 5'h0 |=> !irq_o) else $error("irq without enable"); // RULE26
  AST_DOUBLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_reg == ST_RUN && ctrl_change && wdata_i[`BIT_ON] |=> cnt_reg == $past(conv_clocks) << 1)
    else $error("no double"); // RULE10
  // low clamp mirrors the high one
  AST_SAT_LOW: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    gain_saturation_flag && scaled[18] |-> corrected == `SAT_MIN) else $error("clamp low wrong"); // RULE27
  AST_SAT_FLAG: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_pulse && gain_saturation_flag |=> flags_reg[`FLG_SAT]) else $error("sat flag"); // RULE24
  AST_HALF: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_pulse && active_reg && half_hit |=> flags_reg[`FLG_HALF]) else $error("half flag"); // RULE23
  // a wrap must land back on the start, not one past the end
  AST_WRAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_pulse && active_reg && last_hit && wrap_reg && !dma_rst
    |=> next_reg == $past(start_reg) && count_reg == 13'h0) else $error("wrap"); // RULE15
  AST_NEXT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_pulse && active_reg && !last_hit && !dma_rst && !load_reg
    |=> next_reg == $past(next_reg) + 13'h1) else $error("next address"); // RULE21
  AST_LOAD_START: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    load_reg && !dma_rst && !done_pulse && length_reg != 13'h0 |=> active_reg)
    else $error("load did not start"); // RULE16
  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !read_i |=> rdata_o == 32'h0) else $error("read data outside slot");
  AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (flags_reg & enables_reg) != 5'h0 |=> irq_o) else $error("irq missing"); // RULE26
  // startup always carries the doubled first conversion
  AST_FIRST_DOUBLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_reg == ST_START |-> double_reg) else $error("startup not doubled"); // RULE9
  AST_CFG: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    1'b1 |=> {analog_cfg_o.clk_sel, analog_cfg_o.converter_on} ==
    {$past(ctrl_reg[`BIT_CLK]), $past(ctrl_reg[`BIT_ON])}) else $error("cfg copy"); // RULE7
  COV_WRITE: cover property (@(posedge clk_i) ram_write_o.valid);
  COV_FULL: cover property (@(posedge clk_i) flags_reg[`FLG_FULL]);
  COV_SAT: cover property (@(posedge clk_i) done_pulse && gain_saturation_flag);
  COV_WRAP: cover property (@(posedge clk_i) done_pulse && active_reg && last_hit && wrap_reg);
  COV_OVR: cover property (@(posedge clk_i) done_pulse && !active_reg);
endmodule

// ---- adc_ctrl_params.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
`define OFS_EVENT_FLAGS 16'hA810
`define OFS_EVENT_ENABLES 16'hA850
`define OFS_CONV_CTRL 16'hD004
`define OFS_OFFSET_CORR 16'hD008
`define OFS_GAIN_CORR 16'hD00C
`define OFS_DMA_CTRL 16'hD010
`define OFS_DMA_STATUS 16'hD014
`define OFS_START_ADDR 16'hD018
`define OFS_LENGTH 16'hD01C
`define OFS_NEXT_ADDR 16'hD020
`define OFS_WRITTEN_CNT 16'hD024
`define RST_CONV_CTRL 16'h1800
`define RST_GAIN_CORR 16'h8000
`define RST_START_ADDR 32'h2000_0000
`define CTRL_WMASK 16'hFFFD
`define BIT_ON 0
`define BIT_CLK 2
`define BIT_LOAD 0
`define BIT_WRAP 1
`define BIT_DMA_RST 4
`define FLG_HALF 1
`define FLG_FULL 2
`define FLG_SAT 3
`define FLG_OVR 4
`define FLG_MASK 5'h1E
`define SMP_LSB 13
`define BASE_CLOCKS 32
`define STARTUP_NS 21000
`define FAST_DIV 1
`define SLOW_DIV 6
`define SAT_MAX 16'h7FFF
`define SAT_MIN 16'h8000
`endif

// ---- adc_ctrl_pkg.sv ----
// types shared by the converter control block
package adc_ctrl_pkg;
  typedef struct packed {
    logic [2:0] sample_time_sel;
    logic pos_high_range_sel;
    logic neg_high_range_sel;
    logic [3:0] pos_input_sel;
    logic [3:0] neg_input_sel;
    logic clk_sel;
    logic converter_on;
  } analog_cfg_t;
  typedef struct packed {
    logic valid;
    logic [12:0] addr;
    logic [15:0] data;
  } ram_write_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_START = 3'b010,
    ST_RUN = 3'b100
  } conv_state_t;
endpackage

// ---- adc_result_ram.sv ----
// result ram model written by the dma
`timescale 1ns/1ps
module adc_result_ram
  import adc_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire ram_write_t wr_i
);
  // one halfword per location, so a result never spans two words
  logic [15:0] mem [0:8191];
  always @(posedge clk_i) begin
    if (wr_i.valid === 1'b1) begin
      mem[wr_i.addr] <= wr_i.data;
    end
  end
endmodule
